// *** src/pgio_port.sv ***
/*
  Eight-pin general purpose port: output latch, input and driver type
  registers, pin drive, pull-up control and pin read-back.
  Assumes a processor special-register bus with byte and bit access,
  crossbar control levels and per-pin peripheral signals from outside.
*/
// Notes on behaviour
// - Unassigned, non-analog pins are software-driven general purpose I/O.
// - Port register accepts whole-byte and single-bit accesses.
// - Writes store into the output latch, held until next write.
// - Ordinary reads return sampled pin levels, even for peripheral pins.
// - Read-modify-write instructions read the latch, not the pins.
// - Latch value reaches pins per crossbar; 0 drives low, 1 high.
// - Latch 1 with driver type 0 leaves the pin open-drain.
// - Analog-input pins read as 1; digital inputs read pin level.
// - Input type bit 0 selects analog, 1 selects digital.
// - Analog pins lose pull-up, output driver and input receiver.
// - Driver type bit 0 selects open-drain, 1 push-pull.
// - Driver type bit ignored while the pin is analog.
// - Pins carrying SDA or SCL are always open-drain.
// - Crossbar disabled turns all drivers off; pins keep their input type.
// - Pull-ups on open-drain pins only, off while driving low.
`timescale 1ns/1ps
`default_nettype none
`include "pgio_cfg.svh"
module pgio_port #(
  parameter int NPINS = 8
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire pgio_pkg::pgio_addr_t sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_bit_i,
  input wire pgio_pkg::pgio_bit_t sfr_bitsel_i,
  input wire logic sfr_rmw_i,
  input wire pgio_pkg::pgio_byte_t sfr_wdata_i,
  output pgio_pkg::pgio_byte_t sfr_rdata_o,
  output logic sfr_hit_o,
  input wire logic crossbar_enable_bit_i,
  input wire logic pullup_disable_bit_i,
  input wire logic [NPINS-1:0] crossbar_assign_i,
  input wire logic [NPINS-1:0] periph_out_i,
  input wire logic [NPINS-1:0] smbus_pin_i,
  input wire logic [NPINS-1:0] pin_i,
  output logic [NPINS-1:0] pin_o,
  output logic [NPINS-1:0] pin_oe_o,
  output logic [NPINS-1:0] pullup_en_o,
  output logic [NPINS-1:0] rx_en_o
);
  import pgio_pkg::*;

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // Registers are one byte wide, so the pin count is fixed
  if (NPINS != 8) begin : g_bad_npins
    $error("pgio_port: NPINS must be 8");
  end
  // Read latency figures assume exactly three input stages
  if (`PGIO_SYNC_STAGES != 3) begin : g_bad_sync
    $error("pgio_port: three input stages expected");
  end

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // Shared decode keeps the write and read paths in step
  function automatic logic addr_match(input pgio_addr_t addr,
                                      input pgio_addr_t ofs);
    return addr == ofs;
  endfunction

  function automatic logic [7:0] bit_merge(input logic [7:0] old_v,
                                           input logic [2:0] sel,
                                           input logic val);
    logic [7:0] r;
    r = old_v;
    r[sel] = val;
    return r;
  endfunction

  // ------------------------------------------------------------
  // Storage and nets
  // ------------------------------------------------------------
  pgio_byte_t port_output_latch_r;
  pgio_byte_t port_input_type_select_r;
  pgio_byte_t port_driver_type_select_r;
  pgio_byte_t latch_nxt;
  pgio_byte_t intype_nxt;
  pgio_byte_t drvtype_nxt;
  pgio_byte_t latch_bit_val;
  pgio_byte_t rdata_r;
  pgio_byte_t rdata_nxt;
  pgio_byte_t rdata_sel;
  pgio_byte_t pin_level;
  pgio_byte_t analog;
  pgio_byte_t port_view;
  logic sel_latch;
  logic sel_intype;
  logic sel_drvtype;
  logic wr_latch_byte;
  logic wr_latch_bit;
  logic wr_intype;
  logic wr_drvtype;
  logic rd_latch_pins;
  logic rd_latch_rmw;
  logic rd_intype;
  logic rd_drvtype;
  logic [NPINS-1:0] digital;
  logic [NPINS-1:0] drive_val;
  logic [NPINS-1:0] push_pull;
  logic [NPINS-1:0] oe_lo;
  logic [NPINS-1:0] oe_hi;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  assign sel_latch = addr_match(sfr_addr_i, `PGIO_OFS_LATCH);
  assign sel_intype = addr_match(sfr_addr_i, `PGIO_OFS_INTYPE);
  assign sel_drvtype = addr_match(sfr_addr_i, `PGIO_OFS_DRVTYPE);
  assign sfr_hit_o = sel_latch | sel_intype | sel_drvtype;

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // Bit access only on the port register; the mode registers take bytes
  assign wr_latch_byte = sfr_wr_i & sel_latch & ~sfr_bit_i;
  assign wr_latch_bit = sfr_wr_i & sel_latch & sfr_bit_i;
  assign wr_intype = sfr_wr_i & sel_intype;
  assign wr_drvtype = sfr_wr_i & sel_drvtype;
  // Bit writes merge into the latch, never into the pin levels
  assign latch_bit_val = bit_merge(port_output_latch_r, sfr_bitsel_i, sfr_wdata_i[0]);
  assign latch_nxt = wr_latch_byte ? sfr_wdata_i :
                     wr_latch_bit ? latch_bit_val : port_output_latch_r;
  assign intype_nxt = wr_intype ? sfr_wdata_i : port_input_type_select_r;
  assign drvtype_nxt = wr_drvtype ? sfr_wdata_i : port_driver_type_select_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_output_latch_r <= `PGIO_RST_LATCH;
    end else begin
      port_output_latch_r <= latch_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_input_type_select_r <= `PGIO_RST_INTYPE;
    end else begin
      port_input_type_select_r <= intype_nxt;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      port_driver_type_select_r <= `PGIO_RST_DRVTYPE;
    end else begin
      port_driver_type_select_r <= drvtype_nxt;
    end
  end

  // ------------------------------------------------------------
  // Pin read-back
  // ------------------------------------------------------------
  pgio_sync #(
    .WIDTH(NPINS),
    .RST_VAL(`PGIO_RST_SYNC)
  ) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i(pin_i),
    .level_o(pin_level)
  );

  // Analog inputs read as one; the synchronised pin level is ORed with the analog mask
  assign analog = ~port_input_type_select_r;
  assign port_view = pin_level | analog;
  assign rd_latch_pins = sfr_rd_i & sel_latch & ~sfr_rmw_i;
  assign rd_latch_rmw = sfr_rd_i & sel_latch & sfr_rmw_i;
  assign rd_intype = sfr_rd_i & sel_intype;
  assign rd_drvtype = sfr_rd_i & sel_drvtype;
  // Selects are one-hot, so an AND-OR mux; unmapped reads give zero
  assign rdata_sel = ({8{rd_latch_pins}} & port_view)
                   | ({8{rd_latch_rmw}} & port_output_latch_r)
                   | ({8{rd_intype}} & port_input_type_select_r)
                   | ({8{rd_drvtype}} & port_driver_type_select_r);
  // Read data stands until the next read
  assign rdata_nxt = sfr_rd_i ? rdata_sel : rdata_r;
  assign sfr_rdata_o = rdata_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= `PGIO_RST_RDATA;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  // Combinational, so peripheral data reaches the pad with no added cycle
  assign digital = port_input_type_select_r;
  assign rx_en_o = digital;

  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      // Peripheral pins take crossbar data, free pins take the latch
      assign drive_val[g] = crossbar_assign_i[g] ? periph_out_i[g]
                                                 : port_output_latch_r[g];
      assign push_pull[g] = port_driver_type_select_r[g] & digital[g]
                            & ~smbus_pin_i[g];
      assign oe_lo[g] = ~drive_val[g];
      assign oe_hi[g] = drive_val[g] & push_pull[g];
      assign pin_oe_o[g] = crossbar_enable_bit_i & digital[g]
                           & (oe_lo[g] | oe_hi[g]);
      assign pin_o[g] = drive_val[g] & pin_oe_o[g];
      // Pull-up off while driving low saves static current
      assign pullup_en_o[g] = ~pullup_disable_bit_i & digital[g] & ~push_pull[g]
                              & ~(pin_oe_o[g] & ~drive_val[g]);
    end
  endgenerate
endmodule
`default_nettype wire

// *** src/pgio_cfg.svh ***
/*
  Offsets, reset values and input stage count for the general purpose port block.
  Assumes inclusion by bare name from any design or bench file.
*/
`ifndef PGIO_CFG_SVH
`define PGIO_CFG_SVH
`define PGIO_OFS_LATCH 8'h80
`define PGIO_OFS_INTYPE 8'hF1
`define PGIO_OFS_DRVTYPE 8'hA4
`define PGIO_RST_LATCH 8'hFF
`define PGIO_RST_INTYPE 8'hFF
`define PGIO_RST_DRVTYPE 8'h00
`define PGIO_RST_RDATA 8'h00
`define PGIO_RST_SYNC 8'hFF
`define PGIO_SYNC_STAGES 3
`endif

// *** src/pgio_pkg.sv ***
/*
  Types shared by the port block.
  Assumes the _cfg header supplies all numeric constants.
*/
package pgio_pkg;
  typedef logic [7:0] pgio_byte_t;
  typedef logic [7:0] pgio_addr_t;
  typedef logic [2:0] pgio_bit_t;
endpackage

// *** src/pgio_sync.sv ***
/*
  Three-stage input synchroniser with agreement filter, one per pin.
  Assumes pins are asynchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module pgio_sync #(
  parameter int WIDTH = 8,
  parameter logic [7:0] RST_VAL = 8'hFF
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] level_nxt;
  // Reset value is one byte, so wider ports cannot be served
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("pgio_sync: WIDTH must be 1..8");
  end
  // Change counts only once stages two and three agree
  assign level_nxt = (s2_r & s3_r) | (level_r & (s2_r | s3_r));
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_r <= RST_VAL[WIDTH-1:0];
      s2_r <= RST_VAL[WIDTH-1:0];
      s3_r <= RST_VAL[WIDTH-1:0];
      level_r <= RST_VAL[WIDTH-1:0];
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end
  assign level_o = level_r;
endmodule
`default_nettype wire

// *** bench/pgio_pad_model.sv ***
/*
  Pad model for the eight port pins.
  Assumes an outside driver that always drives a released pin.
*/
`timescale 1ns/1ps
`default_nettype none
module pgio_pad_model (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] ext_i,
  output logic [7:0] pad_o
);
  // Released pins follow the outside driver, never the last driven value
  assign pad_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_i);
endmodule
`default_nettype wire

// *** bench/pgio_port_monitor.sv ***
/*
  Checker for the port block, bound at the foot.
  Assumes one clock and an async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pgio_cfg.svh"
module pgio_port_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_bit_i,
  input wire logic sfr_rmw_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic sfr_hit_o,
  input wire logic crossbar_enable_bit_i,
  input wire logic pullup_disable_bit_i,
  input wire logic [7:0] smbus_pin_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pullup_en_o,
  input wire logic [7:0] rx_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_off; !crossbar_enable_bit_i |-> pin_oe_o == 8'h00; endproperty
  a_off: assert property (p_off) else $error("drive while off");
  property p_ana; ((~rx_en_o) & (pin_oe_o | pullup_en_o)) == 8'h00; endproperty
  a_ana: assert property (p_ana) else $error("analog pin active");
  property p_smb; (smbus_pin_i & pin_oe_o & pin_o) == 8'h00; endproperty
  a_smb: assert property (p_smb) else $error("bus pin driven high");
  property p_pud; pullup_disable_bit_i |-> pullup_en_o == 8'h00; endproperty
  a_pud: assert property (p_pud) else $error("pull-up on");
  property p_low; (pullup_en_o & pin_oe_o & ~pin_o) == 8'h00; endproperty
  a_low: assert property (p_low) else $error("pull-up while low");
  property p_rmw;
    sfr_wr_i && !sfr_bit_i && sfr_addr_i == `PGIO_OFS_LATCH
    ##1 sfr_rd_i && sfr_rmw_i && sfr_addr_i == `PGIO_OFS_LATCH
    |=> sfr_rdata_o == $past(sfr_wdata_i, 2);
  endproperty
  a_rmw: assert property (p_rmw) else $error("latch read-back");
  property p_unm; sfr_rd_i && !sfr_hit_o |=> sfr_rdata_o == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_hold; !sfr_rd_i |=> $stable(sfr_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  c_rmw: cover property (sfr_rd_i && sfr_rmw_i);
  c_drv: cover property (crossbar_enable_bit_i && pin_oe_o != 8'h00);
  c_unm: cover property (sfr_rd_i && !sfr_hit_o);
  c_bit: cover property (sfr_wr_i && sfr_bit_i);
endmodule
bind pgio_port pgio_port_monitor i_pgio_port_monitor (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .sfr_addr_i(sfr_addr_i),
  .sfr_wr_i(sfr_wr_i),
  .sfr_rd_i(sfr_rd_i),
  .sfr_bit_i(sfr_bit_i),
  .sfr_rmw_i(sfr_rmw_i),
  .sfr_wdata_i(sfr_wdata_i),
  .sfr_rdata_o(sfr_rdata_o),
  .sfr_hit_o(sfr_hit_o),
  .crossbar_enable_bit_i(crossbar_enable_bit_i),
  .pullup_disable_bit_i(pullup_disable_bit_i),
  .smbus_pin_i(smbus_pin_i),
  .pin_o(pin_o),
  .pin_oe_o(pin_oe_o),
  .pullup_en_o(pullup_en_o),
  .rx_en_o(rx_en_o)
);
`default_nettype wire

// *** bench/pgio_port_tb.sv ***
/*
  Random bench for the port block with pad model.
  Assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pgio_cfg.svh"
module pgio_port_tb;
  logic clk_i = 0, nrst_i = 0, wr = 0, rd = 0, bt = 0, rmw = 0, xe = 0, pud = 0, hit;
  logic [7:0] a = 0, wd = 0, asg = 0, po = 0, smb = 0, ext = 0, it, dt, lt, v;
  logic [7:0] rdat, pin, pad, oe, pu, rx;
  logic [2:0] bs = 0;
  logic [31:0] s = 32'hE9B2;
  int miscompares = 0, check_count = 0;
  pgio_port i_pgio_port (.clk_i, .nrst_i, .sfr_addr_i(a), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_bit_i(bt), .sfr_bitsel_i(bs), .sfr_rmw_i(rmw), .sfr_wdata_i(wd), .sfr_rdata_o(rdat),
    .sfr_hit_o(hit), .crossbar_enable_bit_i(xe), .pullup_disable_bit_i(pud),
    .crossbar_assign_i(asg), .periph_out_i(po), .smbus_pin_i(smb), .pin_i(pad),
    .pin_o(pin), .pin_oe_o(oe), .pullup_en_o(pu), .rx_en_o(rx));
  pgio_pad_model i_pgio_pad_model (.pin_o(pin), .pin_oe_o(oe), .ext_i(ext), .pad_o(pad));
  initial forever #20 clk_i = ~clk_i;
  function automatic logic [31:0] lf(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic mapped(logic [7:0] ad);
    return ad == `PGIO_OFS_LATCH || ad == `PGIO_OFS_INTYPE || ad == `PGIO_OFS_DRVTYPE;
  endfunction
  task print_verdict;
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(logic [7:0] g, e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %0t seen %h want %h", $time, g, e);
    end
  endtask
  task wrt(logic [7:0] ad, d, logic b = 0, logic [2:0] n = 0);
    @(negedge clk_i);
    {a, wd, bt, bs, wr} = {ad, d, b, n, 1'b1};
    @(negedge clk_i);
    {wr, bt} = 2'b00;
  endtask
  task rdc(logic [7:0] ad, logic m, logic [7:0] e);
    @(negedge clk_i);
    {a, rmw, rd} = {ad, m, 1'b1};
    @(negedge clk_i);
    {rd, rmw} = 2'b00;
    chk(rdat, e);
    chk({7'h00, hit}, {7'h00, mapped(ad)});
  endtask
  // Byte write then latch read on the very next cycle
  task wrr(logic [7:0] d);
    @(negedge clk_i);
    {a, wd, bt, wr} = {8'h80, d, 1'b0, 1'b1};
    @(negedge clk_i);
    {wr, rmw, rd} = 3'b011;
    @(negedge clk_i);
    {rd, rmw} = 2'b00;
    chk(rdat, d);
  endtask
  // Hang guard, well past the expected run length
  initial begin
    #200000;
    miscompares++;
    print_verdict;
  end
  initial begin
    repeat (10) @(negedge clk_i);
    nrst_i = 1;
    rdc(8'hF1, 0, 8'hFF);
    rdc(8'hA4, 0, 8'h00);
    rdc(8'h80, 1, 8'hFF);
    rdc(8'h3C, 0, 8'h00);
    repeat (24) begin
      s = lf(s);
      {ext, lt, dt, it} = s;
      s = lf(s);
      {xe, pud, smb, po, asg} = {s[31:30], s[23:0] & {{16{1'b1}}, {8{s[28]}}}};
      wrt(8'hF1, it);
      wrt(8'hA4, dt);
      wrr(~lt);
      wrt(8'h80, lt);
      rdc(8'h80, 1, lt);
      wrt(8'h80, {7'h00, s[26]}, 1, s[29:27]);
      lt[s[29:27]] = s[26];
      rdc(8'h80, 1, lt);
      v = (asg & po) | (~asg & lt);
      chk(oe, {8{xe}} & it & (~v | (dt & ~smb)));
      chk(pin, v & oe);
      chk(pu, {8{~pud}} & it & ~(dt & ~smb) & ~(oe & ~v));
      chk(rx, it);
      repeat (5) @(negedge clk_i);
      rdc(8'h80, 0, pad | ~it);
    end
    // Mid-run reset must restore every register
    @(negedge clk_i);
    nrst_i = 0;
    @(negedge clk_i);
    nrst_i = 1;
    rdc(8'hF1, 0, 8'hFF);
    rdc(8'hA4, 0, 8'h00);
    rdc(8'h80, 1, 8'hFF);
    print_verdict;
  end
endmodule
`default_nettype wire
